// file: core/pfp_pkg.sv
// package: register map, fields and types of the fault-protection block
`default_nettype none
package pfp_pkg;
   // ****************************************
   // register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [3:0] IDX_CTRL     = 4'h0;
   localparam logic [3:0] IDX_EVMASK   = 4'h2;
   localparam logic [3:0] IDX_FDCTL    = 4'h3;
   localparam logic [3:0] IDX_STATUS   = 4'h4;
   localparam logic [3:0] IDX_DTBOTH   = 4'h6;
   localparam logic [3:0] IDX_DTBOTHB  = 4'h7;
   localparam logic [3:0] IDX_DTLOW    = 4'h8;
   localparam logic [3:0] IDX_DTHIGH   = 4'h9;
   localparam logic [3:0] IDX_DTLOWB   = 4'hA;
   localparam logic [3:0] IDX_DTHIGHB  = 4'hB;
   localparam logic [3:0] IDX_OVREN    = 4'hC;
   localparam int         ADDR_LSB     = 2;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         CTRL_PATTERN   = 5;
   localparam int         CTRL_COMMON    = 4;
   localparam int         FDC_BRKSUP     = 4;
   localparam int         FDC_RESTART    = 2;
   localparam int         ST_FAULT       = 2;
   localparam int         ST_HIGHV       = 1;
   localparam int         ST_LOWV        = 0;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] CTRL_WMASK     = 8'h3F;
   localparam logic [7:0] FDC_WMASK      = 8'h17;

   typedef enum logic [1:0] {
      ACT_NONE     = 2'h0,
      ACT_CLEAROVR = 2'h1,
      ACT_RESERVED = 2'h2,
      ACT_CLEAR_DIRECTION_ACTION = 2'h3
   } pfp_action_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic       patternModeEnable;
      logic       commonChannelSource;
      logic [3:0] deadTimeChannelEnables;
   } pfp_ctrl_t;

   typedef struct packed {
      logic [2:0]  rsvd;
      logic        breakFaultSuppress;
      logic        rsvd3;
      logic        faultRestartSelect;
      pfp_action_t faultActionSelect;
   } pfp_fdctl_t;

   typedef struct packed {
      logic [7:0] lowSideDeadTime;
      logic [7:0] highSideDeadTime;
   } pfp_deadtime_t;
endpackage : pfp_pkg
`default_nettype wire

// file: core/pfp_fault_protect.sv
// fault protection and control registers of the waveform extension
`default_nettype none
module pfp_fault_protect #(
   parameter int EVENT_CHANNELS = 8,
   parameter int DT_CHANNELS    = 4
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   // avalon-mm slave
   input  wire logic [5:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   // event network, debugger and timer
   input  wire logic [EVENT_CHANNELS-1:0] eventChannels,
   input  wire logic                   debugBreakRequest,
   input  wire logic                   timerUpdate,
   input  wire logic                   timerLockUpdateFlag,
   input  wire logic                   extensionLock,
   // outputs to timer, dead-time units and port
   output logic                        timerErrorFlagSet,
   output logic                        faultState,
   output logic [2*DT_CHANNELS-1:0]    outputOverrideEnables,
   output logic [DT_CHANNELS-1:0]      deadTimeChannelEnables,
   output logic                        patternModeEnable,
   output logic                        commonChannelSource,
   output pfp_pkg::pfp_deadtime_t      deadTime,
   output logic                        portDirClear,
   output logic                        portDirRestore,
   output logic [2*DT_CHANNELS-1:0]    portDirMask
);
   // ****************************************
   // parameter checks
   // ****************************************
   if (EVENT_CHANNELS != 8 || DT_CHANNELS != 4) begin : g_badParam
      $error("pfp_fault_protect supports eight event channels and four dead-time channels");
   end

   // ****************************************
   // reset release
   // ****************************************
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   wire logic rstN = rstSync_q;

   // ****************************************
   // functions
   // ****************************************
   // pin pairs of enabled channels
   function automatic logic [7:0] pairMask(input logic [3:0] chEn);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 4; i++) begin
         m[2*i]   = chEn[i];
         m[2*i+1] = chEn[i];
      end
      return m;
   endfunction : pairMask

   function automatic logic [7:0] maskedByte(input logic [7:0] oldV, input logic [7:0] newV,
                                             input logic [7:0] wmask);
      return (oldV & ~wmask) | (newV & wmask);
   endfunction : maskedByte

   // ****************************************
   // registers
   // ****************************************
   pfp_pkg::pfp_ctrl_t  ctrl_q;
   pfp_pkg::pfp_fdctl_t fdctl_q;
   logic [7:0]          evMask_q;
   logic [7:0]          ovrEn_q;
   logic [7:0]          dtLow_q;
   logic [7:0]          dtHigh_q;
   logic [7:0]          dtLowBuf_q;
   logic [7:0]          dtHighBuf_q;
   logic                lowValid_q;
   logic                highValid_q;
   logic                faultFlag_q;
   logic                faultActive_q;
   logic                errPulse_q;
   logic                dirClear_q;
   logic                dirRestore_q;
   logic [7:0]          dirMask_q;
   logic                ack_q;
   logic [31:0]         rdata_q;

   // ****************************************
   // bus handshake
   // ****************************************
   wire logic       busReq  = avs_read | avs_write;
   wire logic       wrTake  = avs_write & ack_q & avs_byteenable[0];
   wire logic [3:0] regIdx  = avs_address[pfp_pkg::ADDR_LSB +: 4];
   wire logic       addrOk  = (avs_address[1:0] == 2'h0);
   wire logic [7:0] wByte   = avs_writedata[7:0];

   // one wait cycle: read data captured then, write applied at the accepting edge
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq & ~ack_q;
      end
   end
   assign avs_waitrequest = busReq & ~ack_q;

   function automatic logic isWr(input logic [3:0] idx);
      return wrTake && addrOk && (regIdx == idx);
   endfunction : isWr

   // ****************************************
   // fault detection
   // ****************************************
   pfp_pkg::pfp_action_t act;
   logic protectOn;
   logic maskedEvent;
   logic brkFault;
   logic faultCond;
   always_comb begin
      act         = fdctl_q.faultActionSelect;
      protectOn   = (act == pfp_pkg::ACT_CLEAROVR) || (act == pfp_pkg::ACT_CLEAR_DIRECTION_ACTION);
      maskedEvent = |(eventChannels & evMask_q);
      brkFault    = protectOn & debugBreakRequest & ~fdctl_q.breakFaultSuppress;
      faultCond   = protectOn & maskedEvent | brkFault;
   end

   wire logic restoreOk = fdctl_q.faultRestartSelect ? ~faultCond
                                                     : ~faultCond & ~faultFlag_q;
   wire logic doRestore = faultActive_q & restoreOk & timerUpdate;
   wire logic newFault  = faultCond & ~faultActive_q;

   // fault state, applied on the edge after the event
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         faultActive_q <= 1'b0;
      end else if (faultCond) begin
         faultActive_q <= 1'b1;
      end else if (doRestore) begin
         faultActive_q <= 1'b0;
      end
   end

   // timer error flag set pulse on each new fault
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         errPulse_q <= 1'b0;
      end else begin
         errPulse_q <= newFault;
      end
   end

   // fault flag: a set in the clearing cycle wins
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         faultFlag_q <= 1'b0;
      end else if (maskedEvent || brkFault) begin
         faultFlag_q <= 1'b1;
      end else if (isWr(pfp_pkg::IDX_STATUS) && wByte[pfp_pkg::ST_FAULT]) begin
         faultFlag_q <= 1'b0;
      end
   end

   // direction clear and restore strobes to the port
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         dirClear_q   <= 1'b0;
         dirRestore_q <= 1'b0;
         dirMask_q    <= pfp_pkg::RST_BYTE;
      end else begin
         dirClear_q   <= newFault & (act == pfp_pkg::ACT_CLEAR_DIRECTION_ACTION);
         dirRestore_q <= doRestore & (act == pfp_pkg::ACT_CLEAR_DIRECTION_ACTION);
         if (faultCond) begin
            dirMask_q <= pairMask(ctrl_q.deadTimeChannelEnables);
         end else if (doRestore) begin
            dirMask_q <= ctrl_q.patternModeEnable ? dtLowBuf_q
                                                   : pairMask(ctrl_q.deadTimeChannelEnables);
         end
      end
   end

   // ****************************************
   // control, mask and fault control registers
   // ****************************************
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ctrl_q   <= pfp_pkg::RST_BYTE;
         evMask_q <= pfp_pkg::RST_BYTE;
         fdctl_q  <= pfp_pkg::RST_BYTE;
      end else begin
         if (isWr(pfp_pkg::IDX_CTRL) && !extensionLock) begin
            ctrl_q <= wByte & pfp_pkg::CTRL_WMASK;
         end
         if (isWr(pfp_pkg::IDX_EVMASK) && !extensionLock) begin
            evMask_q <= wByte;
         end
         if (isWr(pfp_pkg::IDX_FDCTL)) begin
            fdctl_q <= wByte & pfp_pkg::FDC_WMASK;
         end
      end
   end

   // ****************************************
   // output override enables
   // ****************************************
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ovrEn_q <= pfp_pkg::RST_BYTE;
      end else if (faultCond && act == pfp_pkg::ACT_CLEAROVR) begin
         ovrEn_q <= pfp_pkg::RST_BYTE;
      end else if (doRestore && act == pfp_pkg::ACT_CLEAROVR) begin
         ovrEn_q <= ctrl_q.patternModeEnable ? dtLowBuf_q
                                              : pairMask(ctrl_q.deadTimeChannelEnables);
      end else if (isWr(pfp_pkg::IDX_OVREN) && !extensionLock && !faultFlag_q) begin
         ovrEn_q <= wByte;
      end
   end

   // ****************************************
   // dead-time registers and buffers
   // ****************************************
   wire logic copyOk = timerUpdate & ~timerLockUpdateFlag;
   logic wrLowB;
   logic wrHighB;
   logic wrStat;
   // a process, so the strobes track the bus signals read inside isWr
   always_comb begin
      wrLowB  = isWr(pfp_pkg::IDX_DTLOWB) | isWr(pfp_pkg::IDX_DTBOTHB);
      wrHighB = isWr(pfp_pkg::IDX_DTHIGHB) | isWr(pfp_pkg::IDX_DTBOTHB);
      wrStat  = isWr(pfp_pkg::IDX_STATUS);
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         dtLow_q     <= pfp_pkg::RST_BYTE;
         dtLowBuf_q  <= pfp_pkg::RST_BYTE;
         lowValid_q  <= 1'b0;
      end else begin
         if (wrLowB) begin
            dtLowBuf_q <= wByte;
         end
         if (copyOk && lowValid_q) begin
            dtLow_q <= dtLowBuf_q;
         end else if (isWr(pfp_pkg::IDX_DTLOW) || isWr(pfp_pkg::IDX_DTBOTH)) begin
            dtLow_q <= wByte;
         end
         if (wrLowB) begin
            lowValid_q <= 1'b1;
         end else if (copyOk || (wrStat && wByte[pfp_pkg::ST_LOWV])) begin
            lowValid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         dtHigh_q    <= pfp_pkg::RST_BYTE;
         dtHighBuf_q <= pfp_pkg::RST_BYTE;
         highValid_q <= 1'b0;
      end else begin
         if (wrHighB) begin
            dtHighBuf_q <= wByte;
         end
         if (copyOk && highValid_q) begin
            dtHigh_q <= dtHighBuf_q;
         end else if (isWr(pfp_pkg::IDX_DTHIGH) || isWr(pfp_pkg::IDX_DTBOTH)) begin
            dtHigh_q <= wByte;
         end
         if (wrHighB) begin
            highValid_q <= 1'b1;
         end else if (copyOk || (wrStat && wByte[pfp_pkg::ST_HIGHV])) begin
            highValid_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // read data
   // ****************************************
   logic [7:0] rByte;
   always_comb begin
      rByte = pfp_pkg::RST_BYTE;
      if (addrOk) begin
         unique case (regIdx)
            pfp_pkg::IDX_CTRL:    rByte = ctrl_q;
            pfp_pkg::IDX_EVMASK:  rByte = evMask_q;
            pfp_pkg::IDX_FDCTL:   rByte = fdctl_q;
            pfp_pkg::IDX_STATUS: begin
               rByte[pfp_pkg::ST_FAULT] = faultFlag_q;
               rByte[pfp_pkg::ST_HIGHV] = highValid_q;
               rByte[pfp_pkg::ST_LOWV]  = lowValid_q;
            end
            pfp_pkg::IDX_DTLOW:   rByte = dtLow_q;
            pfp_pkg::IDX_DTHIGH:  rByte = dtHigh_q;
            pfp_pkg::IDX_DTLOWB:  rByte = dtLowBuf_q;
            pfp_pkg::IDX_DTHIGHB: rByte = dtHighBuf_q;
            pfp_pkg::IDX_OVREN:   rByte = ovrEn_q;
            default:              rByte = pfp_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= {24'h00_0000, rByte};
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign avs_readdata           = rdata_q;
   assign timerErrorFlagSet      = errPulse_q;
   assign faultState             = faultActive_q;
   assign outputOverrideEnables  = ovrEn_q;
   assign deadTimeChannelEnables = ctrl_q.deadTimeChannelEnables;
   assign patternModeEnable      = ctrl_q.patternModeEnable;
   assign commonChannelSource    = ctrl_q.commonChannelSource;
   assign deadTime               = {dtLow_q, dtHigh_q};
   assign portDirClear           = dirClear_q;
   assign portDirRestore         = dirRestore_q;
   assign portDirMask            = dirMask_q;
endmodule : pfp_fault_protect
`default_nettype wire

// file: sim/pfp_fault_protect_monitor.sv
// assertion checker bound to the fault-protection block ports
`default_nettype none
module pfp_fault_protect_monitor #(
   parameter int EVENT_CHANNELS = 8,
   parameter int DT_CHANNELS    = 4
) (
   input wire logic                        mclk,
   input wire logic                        nrst,
   input wire logic [5:0]                  avs_address,
   input wire logic                        avs_read,
   input wire logic                        avs_write,
   input wire logic [31:0]                 avs_readdata,
   input wire logic                        avs_waitrequest,
   input wire logic [EVENT_CHANNELS-1:0]   eventChannels,
   input wire logic                        debugBreakRequest,
   input wire logic                        timerUpdate,
   input wire logic                        timerErrorFlagSet,
   input wire logic                        faultState,
   input wire logic [2*DT_CHANNELS-1:0]    outputOverrideEnables,
   input wire logic [DT_CHANNELS-1:0]      deadTimeChannelEnables,
   input wire logic                        patternModeEnable,
   input wire logic                        portDirClear,
   input wire logic                        portDirRestore,
   input wire logic [2*DT_CHANNELS-1:0]    portDirMask
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // each dead-time channel owns the pin pair 2i, 2i+1
   function automatic logic [2*DT_CHANNELS-1:0] pairs(input logic [DT_CHANNELS-1:0] e);
      for (int i = 0; i < DT_CHANNELS; i++) pairs[2*i +: 2] = {2{e[i]}};
   endfunction : pairs

   // ****************************************
   // sequences and properties
   // ****************************************
   sequence s_fault_entry; $rose(faultState); endsequence
   sequence s_fault_exit; $fell(faultState); endsequence
   sequence s_access; (avs_read || avs_write) && avs_waitrequest; endsequence

   property p_entry_cause;
      s_fault_entry |-> $past(eventChannels) != '0 || $past(debugBreakRequest);
   endproperty
   property p_entry_action;
      s_fault_entry |-> outputOverrideEnables == '0 || portDirClear;
   endproperty
   property p_err_pulse;
      timerErrorFlagSet |-> $rose(faultState) ##1 !timerErrorFlagSet;
   endproperty
   property p_exit_update;
      s_fault_exit |-> $past(timerUpdate);
   endproperty
   property p_ovr_reload;
      $fell(faultState) && !portDirRestore && !patternModeEnable
         |-> outputOverrideEnables == pairs(deadTimeChannelEnables);
   endproperty
   property p_dir_clear;
      portDirClear |-> portDirMask == pairs(deadTimeChannelEnables) ##1 !portDirClear;
   endproperty
   property p_dir_restore;
      portDirRestore |-> $fell(faultState)
         && (patternModeEnable || portDirMask == pairs(deadTimeChannelEnables));
   endproperty
   property p_wait_one;
      s_access |=> !avs_waitrequest;
   endproperty
   property p_status_zero;
      avs_read && !avs_waitrequest && avs_address[5:2] == pfp_pkg::IDX_STATUS
         |-> avs_readdata[7:3] == 5'h00;
   endproperty

   a_entry_cause: assert property (p_entry_cause)
      else $error("fault entered without an enabled cause");
   a_entry_action: assert property (p_entry_action)
      else $error("fault entered without its action");
   a_err_pulse: assert property (p_err_pulse)
      else $error("timer error pulse not tied to fault entry");
   a_exit_update: assert property (p_exit_update)
      else $error("fault left without timer update");
   a_ovr_reload: assert property (p_ovr_reload)
      else $error("override enables not reloaded from channel pairs");
   a_dir_clear: assert property (p_dir_clear)
      else $error("direction clear mask or pulse wrong");
   a_dir_restore: assert property (p_dir_restore)
      else $error("direction restore mask or timing wrong");
   a_wait_one: assert property (p_wait_one)
      else $error("access not answered after one wait cycle");
   a_status_zero: assert property (p_status_zero)
      else $error("status reserved bits not zero");
endmodule : pfp_fault_protect_monitor

bind pfp_fault_protect pfp_fault_protect_monitor #(
   .EVENT_CHANNELS(EVENT_CHANNELS), .DT_CHANNELS(DT_CHANNELS)
) i_mon (
   .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .eventChannels(eventChannels), .debugBreakRequest(debugBreakRequest),
   .timerUpdate(timerUpdate), .timerErrorFlagSet(timerErrorFlagSet), .faultState(faultState),
   .outputOverrideEnables(outputOverrideEnables), .deadTimeChannelEnables(deadTimeChannelEnables),
   .patternModeEnable(patternModeEnable), .portDirClear(portDirClear),
   .portDirRestore(portDirRestore), .portDirMask(portDirMask)
);
`default_nettype wire

// file: sim/pfp_timer_model.sv
// timer model: counts while enabled and emits the update pulse
`default_nettype none
module pfp_timer_model #(
   parameter int PERIOD = 5
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic runTimer,
   output var  logic timerUpdate
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q       <= 8'h00;
         timerUpdate <= 1'b0;
      end else begin
         timerUpdate <= runTimer && cnt_q == 8'(PERIOD - 1);
         cnt_q       <= (runTimer && cnt_q != 8'(PERIOD - 1)) ? cnt_q + 8'h01 : 8'h00;
      end
   end
endmodule : pfp_timer_model
`default_nettype wire

// file: sim/pwm_fault_protection_test.sv
// self-checking bench: register access, fault entry and recovery
`default_nettype none
module pwm_fault_protection_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] KC = pfp_pkg::IDX_CTRL;
   localparam logic [3:0] KM = pfp_pkg::IDX_EVMASK;
   localparam logic [3:0] KF = pfp_pkg::IDX_FDCTL;
   localparam logic [3:0] KS = pfp_pkg::IDX_STATUS;
   localparam logic [3:0] KO = pfp_pkg::IDX_OVREN;
   logic                   mclk = 1'b0;
   logic                   nrst = 1'b0;
   logic [5:0]             avs_address = 6'h00;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h00000000;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic [7:0]             eventChannels = 8'h00;
   logic                   debugBreakRequest = 1'b0;
   logic                   extensionLock = 1'b0;
   logic                   runTimer = 1'b0;
   logic                   timerLockUpdateFlag = 1'b0;
   logic                   timerUpdate, timerErrorFlagSet, faultState, portDirClear;
   logic                   patternModeEnable, commonChannelSource, portDirRestore;
   logic [7:0]             outputOverrideEnables, portDirMask, rd;
   logic [7:0]             clrMask = 8'h00;
   logic [7:0]             rstMask = 8'h00;
   logic [3:0]             deadTimeChannelEnables;
   pfp_pkg::pfp_deadtime_t deadTime;
   int                     fails = 0;
   int                     checks_done = 0;
   int                     errCnt = 0;

   always #5 mclk = ~mclk;

   pfp_fault_protect i_dut (
      .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .eventChannels(eventChannels), .debugBreakRequest(debugBreakRequest),
      .timerUpdate(timerUpdate), .timerLockUpdateFlag(timerLockUpdateFlag),
      .extensionLock(extensionLock),
      .timerErrorFlagSet(timerErrorFlagSet), .faultState(faultState),
      .outputOverrideEnables(outputOverrideEnables),
      .deadTimeChannelEnables(deadTimeChannelEnables), .patternModeEnable(patternModeEnable),
      .commonChannelSource(commonChannelSource), .deadTime(deadTime),
      .portDirClear(portDirClear), .portDirRestore(portDirRestore), .portDirMask(portDirMask)
   );
   pfp_timer_model #(.PERIOD(5)) i_timer (
      .mclk(mclk), .nrst(nrst), .runTimer(runTimer), .timerUpdate(timerUpdate)
   );

   // one-cycle strobes are captured here so tests can look later
   always @(posedge mclk) begin
      if (portDirClear) clrMask <= portDirMask;
      if (portDirRestore) rstMask <= portDirMask;
      if (timerErrorFlagSet) errCnt <= errCnt + 1;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
      int n;
      @(posedge mclk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= {24'h000000, wd};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      rd = avs_readdata[7:0];
      if (n >= 64) begin
         fails++;
         conclude();
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rchk(input logic [3:0] idx, input logic [7:0] exp, input string what);
      bus(1'b0, idx, 8'h00);
      chk(what, exp, rd);
   endtask : rchk

   // set event and break levels, then allow the two-cycle reaction time
   task automatic drive(input logic [7:0] ch, input logic brk);
      @(posedge mclk);
      eventChannels     <= ch;
      debugBreakRequest <= brk;
      repeat (2) @(posedge mclk);
      #1;
   endtask : drive

   task automatic upd();
      int n;
      @(posedge mclk);
      runTimer <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (timerUpdate !== 1'b1 && n < 64);
      runTimer <= 1'b0;
      if (n >= 64) begin
         fails++;
         conclude();
      end
      @(posedge mclk);
      #1;
   endtask : upd

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rchk(KS, 8'h00, "status");
      rchk(KC, 8'h00, "ctrl");
      rchk(4'h5, 8'h00, "unmapped");
      $display("test reset done");
      bus(1'b1, KC, 8'h3F);
      rchk(KC, 8'h3F, "ctrl");
      chk("ctrlOut", 8'h3F, {2'b00, patternModeEnable, commonChannelSource,
          deadTimeChannelEnables});
      extensionLock <= 1'b1;
      bus(1'b1, KC, 8'h05);
      bus(1'b1, KM, 8'hFF);
      bus(1'b1, KO, 8'hFF);
      extensionLock <= 1'b0;
      rchk(KC, 8'h3F, "ctrlLocked");
      rchk(KM, 8'h00, "maskLocked");
      rchk(KO, 8'h00, "ovrLocked");
      $display("test control and lock done");
      bus(1'b1, KC, 8'h05);
      bus(1'b1, KO, 8'hFF);
      bus(1'b1, KM, 8'h04);
      bus(1'b1, KF, 8'h01);
      drive(8'h02, 1'b0);
      chk("unmaskedFault", 8'h00, {7'h00, faultState});
      chk("ovrPins", 8'hFF, outputOverrideEnables);
      drive(8'h04, 1'b0);
      chk("faultState", 8'h01, {7'h00, faultState});
      chk("ovrCleared", 8'h00, outputOverrideEnables);
      chk("errPulses", 8'h01, 8'(errCnt));
      drive(8'h00, 1'b0);
      rchk(KS, 8'h04, "flagSet");
      bus(1'b1, KO, 8'hAA);
      rchk(KO, 8'h00, "ovrInFault");
      bus(1'b1, KS, 8'h00);
      upd();
      chk("latchedHold", 8'h01, {7'h00, faultState});
      bus(1'b1, KS, 8'h04);
      rchk(KS, 8'h00, "flagClear");
      upd();
      chk("latchedExit", 8'h00, {7'h00, faultState});
      chk("ovrReload", 8'h33, outputOverrideEnables);
      $display("test latched clear override done");
      bus(1'b1, KF, 8'h07);
      drive(8'h04, 1'b0);
      chk("dirFault", 8'h01, {7'h00, faultState});
      chk("dirClearMask", 8'h33, clrMask);
      upd();
      chk("cycleHold", 8'h01, {7'h00, faultState});
      drive(8'h00, 1'b0);
      upd();
      chk("cycleExit", 8'h00, {7'h00, faultState});
      chk("dirRestoreMask", 8'h33, rstMask);
      $display("test cycle direction clear done");
      for (int a = 0; a < 4; a += 2) begin
         bus(1'b1, KS, 8'h04);
         bus(1'b1, KF, 8'(a));
         drive(8'h04, 1'b0);
         chk("noAction", 8'h00, {7'h00, faultState});
         chk("noActionOvr", 8'h33, outputOverrideEnables);
         drive(8'h00, 1'b0);
      end
      $display("test inactive actions done");
      bus(1'b1, KS, 8'h04);
      bus(1'b1, KF, 8'h05);
      drive(8'h00, 1'b1);
      chk("breakFault", 8'h01, {7'h00, faultState});
      drive(8'h00, 1'b0);
      upd();
      chk("breakExit", 8'h00, {7'h00, faultState});
      chk("breakOvr", 8'h33, outputOverrideEnables);
      bus(1'b1, KF, 8'h15);
      drive(8'h00, 1'b1);
      chk("breakSuppressed", 8'h00, {7'h00, faultState});
      drive(8'h00, 1'b0);
      $display("test debug break done");
      bus(1'b1, KS, 8'h04);
      bus(1'b1, KC, 8'h25);
      bus(1'b1, pfp_pkg::IDX_DTLOWB, 8'h5A);
      rchk(KS, 8'h01, "lowValid");
      bus(1'b1, KF, 8'h01);
      drive(8'h04, 1'b0);
      drive(8'h00, 1'b0);
      bus(1'b1, KS, 8'h04);
      upd();
      chk("patternOvr", 8'h5A, outputOverrideEnables);
      chk("lowCopied", 8'h5A, deadTime.lowSideDeadTime);
      rchk(KS, 8'h00, "validCleared");
      timerLockUpdateFlag <= 1'b1;
      bus(1'b1, pfp_pkg::IDX_DTHIGHB, 8'h3C);
      upd();
      chk("highHeld", 8'h00, deadTime.highSideDeadTime);
      rchk(KS, 8'h02, "highValidHeld");
      timerLockUpdateFlag <= 1'b0;
      upd();
      chk("highCopied", 8'h3C, deadTime.highSideDeadTime);
      $display("test pattern mode done");
      conclude();
   end
endmodule : pwm_fault_protection_test
`default_nettype wire
